// ===== hw/scd_decoder.sv
// module: command decoder and channel command executor
//
// Overview of operation
// - serial channel opcodes 0000..1010 decoded as listed, except 1001, which is undefined
// - 0101 graceful halt, or transfer engine init
// - stop aborts after transmit FIFO drains, stays
// - restart, tx init or both-init resumes a stopped transmitter
// - both-init restores rx and tx reset values
// - rx init touches receive parameters only
// - tx init touches transmit parameters only
// - frame search drops frame, hunts new one
// - enable low resets transmitter; descriptor ready restarts it unless stopped
module scd_decoder
  import scd_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  input wire logic [OP_W-1:0] CMD_OPCODE,
  input wire logic [TGT_W-1:0] CMD_TARGET,
  input wire logic [CH_W-1:0] CMD_CHANNEL,
  output logic CMD_READY,
  output logic CMD_DONE,
  output logic CMD_UNDEF,
  output logic DISP_VALID,
  output logic [TGT_W-1:0] DISP_TARGET,
  output logic [OP_W-1:0] DISP_OPCODE,
  output logic [CH_W-1:0] DISP_CHANNEL,
  input wire logic [NUM_CH-1:0] TX_FIFO_EMPTY,
  input wire logic [NUM_CH-1:0] TX_FRAME_IDLE,
  input wire logic [NUM_CH-1:0] TX_ENABLE,
  input wire logic [NUM_CH-1:0] TX_DESC_READY,
  output logic [NUM_CH-1:0] TX_STOPPED,
  output logic [NUM_CH-1:0] TX_RUN,
  output logic [NUM_CH-1:0] TX_RESET,
  output logic [NUM_CH-1:0] RX_HUNT,
  output logic [NUM_CH-1:0] RX_CLOSE,
  output logic [NUM_CH-1:0] GROUP_SET,
  output logic [NUM_CH-1:0] CHECKSUM_CLR,
  input wire logic PARAM_WE,
  input wire logic PARAM_SEL_TX,
  input wire logic [CH_W-1:0] PARAM_CHANNEL,
  input wire logic [PARAM_W-1:0] PARAM_WDATA,
  output logic [PARAM_W-1:0] PARAM_RDATA
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    scd_state_t state; // decoder phase
    logic [OP_W-1:0] op; // captured opcode
    logic [TGT_W-1:0] tgt; // captured target
    logic [CH_W-1:0] ch; // captured channel
    logic [NUM_CH-1:0] stopped; // transmitter halted by command
    logic done; // command finished pulse
    logic undef; // undefined command pulse
    logic disp; // dispatch pulse to other engines
    logic [NUM_CH-1:0] run; // transmitter may fetch
    logic [NUM_CH-1:0] txrst; // transmitter held in reset
    logic [NUM_CH-1:0] hunt; // frame search pulse
    logic [NUM_CH-1:0] close; // close receive descriptor pulse
    logic [NUM_CH-1:0] group; // group address pulse
    logic [NUM_CH-1:0] sumclr; // checksum clear pulse
  } scd_st_t;

  scd_st_t s_q;
  scd_st_t s_d;
  logic op_ok; // opcode defined for captured target

  scd_mem_if mif ();

  // ----------------------------------------------------------------
  // opcode table per target
  // ----------------------------------------------------------------
  // codes 1100..1111 fall out as undefined for every target
  function automatic logic op_defined(input logic [TGT_W-1:0] t,
                                      input logic [OP_W-1:0] o);
    logic r;
    r = 1'b0;
    case (t)
      TGT_SERIAL: r = (o <= OP_CLR_SUM_OR_ABORT) &&
                      (o != OP_LINE_TIMEOUT);
      TGT_MGMT_UART: r = (o <= OP_CLOSE_RX) && (o != OP_GRACE_OR_XFER);
      TGT_MGMT_LINE: r = (o == OP_INIT_BOTH) || (o == OP_LINE_TIMEOUT) ||
                         (o == OP_CLR_SUM_OR_ABORT);
      TGT_PERIPH: r = (o <= OP_INIT_TX) || (o == OP_CLOSE_RX);
      TGT_XFER: r = (o == OP_GRACE_OR_XFER);
      TGT_TIMER: r = (o == OP_GROUP_OR_TIMER);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  assign op_ok = op_defined(s_q.tgt, s_q.op);

  // ----------------------------------------------------------------
  // parameter memory
  // ----------------------------------------------------------------
  // restores happen only in the execute cycle of a serial channel init
  assign mif.we = PARAM_WE;
  assign mif.sel_tx = PARAM_SEL_TX;
  assign mif.ch = PARAM_CHANNEL;
  assign mif.wdata = PARAM_WDATA;
  assign mif.init_ch = s_q.ch;
  assign mif.init_rx = (s_q.state == ST_EXEC) && (s_q.tgt == TGT_SERIAL) &&
                       ((s_q.op == OP_INIT_BOTH) ||
                        (s_q.op == OP_INIT_RX));
  assign mif.init_tx = (s_q.state == ST_EXEC) && (s_q.tgt == TGT_SERIAL) &&
                       ((s_q.op == OP_INIT_BOTH) ||
                        (s_q.op == OP_INIT_TX));
  assign PARAM_RDATA = mif.rdata;

  scd_param_mem u_mem (
    .clk (CORE_CLK),
    .rst_n (RST_N),
    .mif (mif)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign CMD_READY = (s_q.state == ST_IDLE);
  assign CMD_DONE = s_q.done;
  assign CMD_UNDEF = s_q.undef;
  assign DISP_VALID = s_q.disp;
  assign DISP_TARGET = s_q.tgt;
  assign DISP_OPCODE = s_q.op;
  assign DISP_CHANNEL = s_q.ch;
  assign TX_STOPPED = s_q.stopped;
  assign TX_RUN = s_q.run;
  assign TX_RESET = s_q.txrst;
  assign RX_HUNT = s_q.hunt;
  assign RX_CLOSE = s_q.close;
  assign GROUP_SET = s_q.group;
  assign CHECKSUM_CLR = s_q.sumclr;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.undef = 1'b0;
    s_d.disp = 1'b0;
    s_d.hunt = '0;
    s_d.close = '0;
    s_d.group = '0;
    s_d.sumclr = '0;
    case (s_q.state)
      // take a command only while idle; others wait on ready
      ST_IDLE: begin
        if (CMD_VALID) begin
          s_d.op = CMD_OPCODE;
          s_d.tgt = CMD_TARGET;
          s_d.ch = CMD_CHANNEL;
          s_d.state = ST_EXEC;
        end
      end
      // one cycle of decode and action
      ST_EXEC: begin
        s_d.state = ST_IDLE;
        s_d.done = 1'b1;
        if (!op_ok) begin
          s_d.undef = 1'b1;
        end else if (s_q.tgt != TGT_SERIAL) begin
          s_d.disp = 1'b1; // other engines do their own work
        end else begin
          case (s_q.op)
            OP_INIT_BOTH, OP_INIT_TX: begin
              // a fresh transmit state is not a halted one
              s_d.stopped[s_q.ch] = 1'b0;
            end
            // receive init leaves the transmit state alone; the entry
            // itself is restored by the memory strobe above
            OP_INIT_RX: s_d.stopped = s_q.stopped;
            OP_FRAME_SEARCH: s_d.hunt[s_q.ch] = 1'b1;
            OP_STOP_TX, OP_GRACE_OR_XFER: begin
              s_d.state = ST_DRAIN;
              s_d.done = 1'b0;
            end
            OP_RESTART_TX: s_d.stopped[s_q.ch] = 1'b0;
            OP_CLOSE_RX: s_d.close[s_q.ch] = 1'b1;
            OP_GROUP_OR_TIMER: s_d.group[s_q.ch] = 1'b1;
            OP_CLR_SUM_OR_ABORT: s_d.sumclr[s_q.ch] = 1'b1;
            default: s_d.undef = 1'b1;
          endcase
        end
      end
      // stop waits for an empty FIFO, graceful halt for frame end;
      // a disabled transmitter has nothing left to send
      ST_DRAIN: begin
        if (!TX_ENABLE[s_q.ch] ||
            ((s_q.op == OP_STOP_TX) ? TX_FIFO_EMPTY[s_q.ch]
                                    : TX_FRAME_IDLE[s_q.ch])) begin
          s_d.stopped[s_q.ch] = 1'b1;
          s_d.state = ST_IDLE;
          s_d.done = 1'b1;
        end
      end
      default: s_d.state = ST_IDLE;
    endcase
    // transmitter gating per channel: reset while disabled, fetch
    // from the saved pointer once enabled, not halted, and ready
    for (int i = 0; i < NUM_CH; i++) begin
      s_d.txrst[i] = ~TX_ENABLE[i];
      s_d.run[i] = TX_ENABLE[i] & ~s_d.stopped[i] &
                   TX_DESC_READY[i];
    end
  end

  // registers with synchronous reset
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.txrst <= '1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ===== hw/scd_mem_if.sv
// interface: decoder to parameter memory link
interface scd_mem_if;
  import scd_pkg::*;
  logic we; // software write strobe
  logic sel_tx; // 1 selects transmit entry
  logic [CH_W-1:0] ch; // software access channel
  logic [PARAM_W-1:0] wdata; // software write data
  logic [PARAM_W-1:0] rdata; // registered read data
  logic init_rx; // restore receive entry
  logic init_tx; // restore transmit entry
  logic [CH_W-1:0] init_ch; // channel being restored
  modport ctrl (output we, sel_tx, ch, wdata, init_rx, init_tx, init_ch,
                input rdata);
  modport mem (input we, sel_tx, ch, wdata, init_rx, init_tx, init_ch,
               output rdata);
endinterface

// ===== hw/scd_param_mem.sv
// module: per-channel transmit and receive parameter memory
module scd_param_mem
  import scd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  scd_mem_if.mem mif
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_CH-1:0][PARAM_W-1:0] rx; // receive entries
    logic [NUM_CH-1:0][PARAM_W-1:0] tx; // transmit entries
    logic [PARAM_W-1:0] rdata; // read data register
  } scd_mem_st_t;

  scd_mem_st_t s_q;
  scd_mem_st_t s_d;

  assign mif.rdata = s_q.rdata;

  // next state: restore beats a software write in the same cycle,
  // since the command must leave the entry at its reset value
  always_comb begin
    s_d = s_q;
    if (mif.we) begin
      if (mif.sel_tx) begin
        s_d.tx[mif.ch] = mif.wdata;
      end else begin
        s_d.rx[mif.ch] = mif.wdata;
      end
    end
    if (mif.init_rx) begin
      s_d.rx[mif.init_ch] = RX_PARAM_RST;
    end
    if (mif.init_tx) begin
      s_d.tx[mif.init_ch] = TX_PARAM_RST;
    end
    // read port shows the stored value of the addressed entry
    s_d.rdata = mif.sel_tx ? s_q.tx[mif.ch] : s_q.rx[mif.ch];
  end

  // registers with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.rx <= {NUM_CH{RX_PARAM_RST}};
      s_q.tx <= {NUM_CH{TX_PARAM_RST}};
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ===== hw/scd_pkg.sv
// package: constants and types of the serial channel command decoder
package scd_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4; // serial controller channels
  localparam int CH_W = 2; // channel select width
  localparam int OP_W = 4; // opcode width
  localparam int TGT_W = 3; // target select width
  localparam int PARAM_W = 16; // one parameter memory entry

  // ----------------------------------------------------------------
  // parameter memory values seen after processor reset
  // ----------------------------------------------------------------
  localparam logic [PARAM_W-1:0] RX_PARAM_RST = 16'h0000;
  localparam logic [PARAM_W-1:0] TX_PARAM_RST = 16'h0000;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [OP_W-1:0] OP_INIT_BOTH = 4'h0;
  localparam logic [OP_W-1:0] OP_INIT_RX = 4'h1;
  localparam logic [OP_W-1:0] OP_INIT_TX = 4'h2;
  localparam logic [OP_W-1:0] OP_FRAME_SEARCH = 4'h3;
  localparam logic [OP_W-1:0] OP_STOP_TX = 4'h4;
  localparam logic [OP_W-1:0] OP_GRACE_OR_XFER = 4'h5; // graceful halt / engine init
  localparam logic [OP_W-1:0] OP_RESTART_TX = 4'h6;
  localparam logic [OP_W-1:0] OP_CLOSE_RX = 4'h7;
  localparam logic [OP_W-1:0] OP_GROUP_OR_TIMER = 4'h8;
  localparam logic [OP_W-1:0] OP_LINE_TIMEOUT = 4'h9;
  localparam logic [OP_W-1:0] OP_CLR_SUM_OR_ABORT = 4'hA;

  // ----------------------------------------------------------------
  // targets
  // ----------------------------------------------------------------
  localparam logic [TGT_W-1:0] TGT_SERIAL = 3'h0;
  localparam logic [TGT_W-1:0] TGT_MGMT_UART = 3'h1;
  localparam logic [TGT_W-1:0] TGT_MGMT_LINE = 3'h2;
  localparam logic [TGT_W-1:0] TGT_PERIPH = 3'h3;
  localparam logic [TGT_W-1:0] TGT_XFER = 3'h4;
  localparam logic [TGT_W-1:0] TGT_TIMER = 3'h5;

  // ----------------------------------------------------------------
  // decoder state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DRAIN = 2'b10
  } scd_state_t;

endpackage

// ===== test/scd_decoder_chk.sv
// checker: timing relations at the command decoder ports
module scd_decoder_chk
  import scd_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  input wire logic [OP_W-1:0] CMD_OPCODE,
  input wire logic [TGT_W-1:0] CMD_TARGET,
  input wire logic CMD_READY,
  input wire logic CMD_DONE,
  input wire logic CMD_UNDEF,
  input wire logic [NUM_CH-1:0] TX_ENABLE,
  input wire logic [NUM_CH-1:0] TX_DESC_READY,
  input wire logic [NUM_CH-1:0] TX_STOPPED,
  input wire logic [NUM_CH-1:0] TX_RUN,
  input wire logic [NUM_CH-1:0] TX_RESET
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic take; // command accepted at this edge
  logic halt; // halts wait on the channel, so no fixed latency
  assign take = CMD_VALID && CMD_READY;
  assign halt = CMD_TARGET == TGT_SERIAL &&
                (CMD_OPCODE == OP_STOP_TX || CMD_OPCODE == OP_GRACE_OR_XFER);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  done_two_a: assert property (take && !halt |-> ##2 CMD_DONE)
    else $error("done not two cycles after take");
  hold_busy_a: assert property (take |=> !CMD_READY)
    else $error("ready stayed high after take");
  halt_wait_a: assert property (take && halt |=> !CMD_DONE ##1 !CMD_DONE)
    else $error("halt finished too early");
  undef_op_a: assert property (take && CMD_OPCODE >= 4'hC |->
    ##2 (CMD_UNDEF && CMD_DONE))
    else $error("reserved opcode not flagged");
  undef_done_a: assert property (CMD_UNDEF |-> CMD_DONE)
    else $error("undefined flag without done");
  done_ready_a: assert property (CMD_DONE |-> CMD_READY ##1 !CMD_DONE)
    else $error("done not a single cycle with ready");
  reset_lag_a: assert property ($past(RST_N) |->
    TX_RESET == ~$past(TX_ENABLE))
    else $error("transmitter reset does not follow enable");
  run_gate_a: assert property ($past(RST_N) |->
    (TX_RUN & ~($past(TX_ENABLE) & $past(TX_DESC_READY))) == '0)
    else $error("transmitter runs without enable and descriptor");
  run_stop_a: assert property ((TX_RUN & TX_STOPPED) == '0)
    else $error("stopped channel still running");
  stop_rise_a: assert property ($past(RST_N) &&
    (TX_STOPPED & ~$past(TX_STOPPED)) != '0 |-> CMD_DONE)
    else $error("channel stopped outside a command");
endmodule

// ===== test/tb_top.sv
// testbench: directed scenarios for the command decoder
module tb_top
  import scd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'h0, rst_n = 1'h0, valid = 1'h0; // clock, reset, request
  logic [3:0] op = 4'h0, fe = 4'h0, idle = 4'h0, en = 4'h0, dsc = 4'h0;
  logic [2:0] tgt = 3'h0; // command target
  logic [1:0] ch = 2'h0, pch = 2'h0; // command and param channel
  logic we = 1'h0, sel = 1'h0; // param write, tx entry select
  logic [15:0] wd = 16'h0000, rd; // param data
  logic ready, done, undef, dv;
  logic [2:0] dtgt;
  logic [1:0] dch; // dispatched channel
  logic [3:0] dop, stop, run, trst, hunt, close, grp, csum;
  logic done_s = 1'h0, undef_s = 1'h0, disp_s = 1'h0; // sticky pulses
  logic [15:0] pul_s = 16'h0000; // sticky channel pulses
  int n_errors = 0, n_checks = 0;
  always #10 clk = ~clk;
  scd_decoder u_dut (.CORE_CLK(clk), .RST_N(rst_n), .CMD_VALID(valid),
    .CMD_OPCODE(op), .CMD_TARGET(tgt), .CMD_CHANNEL(ch), .CMD_READY(ready),
    .CMD_DONE(done), .CMD_UNDEF(undef), .DISP_VALID(dv), .DISP_TARGET(dtgt),
    .DISP_OPCODE(dop), .DISP_CHANNEL(dch), .TX_FIFO_EMPTY(fe),
    .TX_FRAME_IDLE(idle), .TX_ENABLE(en), .TX_DESC_READY(dsc),
    .TX_STOPPED(stop), .TX_RUN(run), .TX_RESET(trst), .RX_HUNT(hunt),
    .RX_CLOSE(close), .GROUP_SET(grp), .CHECKSUM_CLR(csum), .PARAM_WE(we),
    .PARAM_SEL_TX(sel), .PARAM_CHANNEL(pch), .PARAM_WDATA(wd),
    .PARAM_RDATA(rd));
  // pulses last one cycle, so latch them for the scenario to judge
  always @(posedge clk) begin
    if (done === 1'h1) done_s <= 1'h1;
    if (undef === 1'h1) undef_s <= 1'h1;
    if (dv === 1'h1) disp_s <= 1'h1;
    pul_s <= pul_s | {csum, grp, close, hunt};
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wdone();
    int n;
    n = 0;
    while (done_s !== 1'h1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("done", done_s, 1'h1);
  endtask
  // request is held until the edge that takes it
  task automatic cmd(input logic [3:0] o, input logic [2:0] t,
                     input logic [1:0] c, input bit wt);
    int n;
    @(negedge clk);
    {op, tgt, ch, valid} = {o, t, c, 1'h1};
    n = 0;
    while (ready !== 1'h1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("ready", ready, 1'h1);
    @(negedge clk);
    valid = 1'h0;
    // pulses of the command before are latched by now, so start clean
    {done_s, undef_s, disp_s, pul_s} = '0;
    if (wt) wdone();
  endtask
  task automatic pwr(input logic s, input logic [1:0] c, input logic [15:0] d);
    @(negedge clk);
    {we, sel, pch, wd} = {1'h1, s, c, d};
    @(negedge clk);
    we = 1'h0;
  endtask
  task automatic prd(input logic s, input logic [1:0] c, input logic [15:0] e);
    @(negedge clk);
    {sel, pch} = {s, c};
    repeat (2) @(negedge clk);
    chk("param", rd, e);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_init();
    chk("tx reset", trst, 4'hF);
    pwr(1'h0, 2'h1, 16'hA5A5);
    pwr(1'h1, 2'h1, 16'h5A5A);
    cmd(OP_INIT_RX, TGT_SERIAL, 2'h1, 1'h1);
    chk("rx init undef", undef_s, 1'h0);
    prd(1'h0, 2'h1, RX_PARAM_RST);
    prd(1'h1, 2'h1, 16'h5A5A);
    pwr(1'h0, 2'h1, 16'hC3C3);
    cmd(OP_INIT_TX, TGT_SERIAL, 2'h1, 1'h1);
    prd(1'h1, 2'h1, TX_PARAM_RST);
    prd(1'h0, 2'h1, 16'hC3C3);
    pwr(1'h1, 2'h1, 16'h1234);
    cmd(OP_INIT_BOTH, TGT_SERIAL, 2'h1, 1'h1);
    prd(1'h0, 2'h1, RX_PARAM_RST);
    prd(1'h1, 2'h1, TX_PARAM_RST);
  endtask
  task automatic t_pulse();
    logic [3:0] ops [4] = '{OP_FRAME_SEARCH, OP_CLOSE_RX, OP_GROUP_OR_TIMER,
                            OP_CLR_SUM_OR_ABORT};
    for (int i = 0; i < 4; i++) begin
      cmd(ops[i], TGT_SERIAL, 2'h2, 1'h1);
      chk("pulse", pul_s, 16'h0004 << (4 * i));
    end
    for (int i = 9; i < 16; i++) begin
      // 1010 clears the checksum, so it is not undefined here
      if (i == 10) continue;
      cmd(i[3:0], TGT_SERIAL, 2'h2, 1'h1);
      chk("undef pulse", {undef_s, pul_s[14:0]}, 16'h8000);
    end
    // a stop on a disabled channel drains in one cycle, so the next
    // request meets ready low and must wait, not get lost
    cmd(OP_STOP_TX, TGT_SERIAL, 2'h0, 1'h0);
    cmd(OP_CLOSE_RX, TGT_SERIAL, 2'h1, 1'h1);
    chk("held close", pul_s[7:4], 4'h2);
    chk("held stop", stop, 4'h1);
    cmd(OP_RESTART_TX, TGT_SERIAL, 2'h0, 1'h1);
    chk("restart", stop, 4'h0);
  endtask
  task automatic t_stop();
    {en, dsc} = {4'hF, 4'hF};
    repeat (3) @(negedge clk);
    chk("run", run, 4'hF);
    cmd(OP_STOP_TX, TGT_SERIAL, 2'h3, 1'h0);
    repeat (5) @(negedge clk);
    chk("early done", done_s, 1'h0);
    fe[3] = 1'h1;
    wdone();
    chk("stop run", {stop, run}, 8'h87);
    cmd(OP_GRACE_OR_XFER, TGT_SERIAL, 2'h0, 1'h0);
    fe = 4'hF;
    repeat (5) @(negedge clk);
    chk("early done", done_s, 1'h0);
    idle[0] = 1'h1;
    wdone();
    chk("stopped", stop, 4'h9);
    cmd(OP_RESTART_TX, TGT_SERIAL, 2'h3, 1'h1);
    repeat (2) @(negedge clk);
    chk("stop run", {stop, run}, 8'h1E);
    en = 4'h0;
    repeat (2) @(negedge clk);
    chk("reset run", {trst, run}, 8'hF0);
  endtask
  task automatic t_disp();
    cmd(OP_GRACE_OR_XFER, TGT_XFER, 2'h2, 1'h1);
    chk("disp", {disp_s, undef_s, dtgt, dop, dch}, 11'h516);
    cmd(OP_GROUP_OR_TIMER, TGT_TIMER, 2'h0, 1'h1);
    chk("disp", {disp_s, undef_s}, 2'h2);
    cmd(OP_GRACE_OR_XFER, TGT_TIMER, 2'h0, 1'h1);
    chk("disp", {disp_s, undef_s}, 2'h1);
  endtask
  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    t_init();
    t_pulse();
    t_stop();
    t_disp();
    report_and_stop();
  end
  // the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule
bind scd_decoder scd_decoder_chk u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .CMD_VALID(CMD_VALID), .CMD_OPCODE(CMD_OPCODE), .CMD_TARGET(CMD_TARGET),
  .CMD_READY(CMD_READY), .CMD_DONE(CMD_DONE), .CMD_UNDEF(CMD_UNDEF),
  .TX_ENABLE(TX_ENABLE), .TX_DESC_READY(TX_DESC_READY),
  .TX_STOPPED(TX_STOPPED), .TX_RUN(TX_RUN), .TX_RESET(TX_RESET));
